// File: src/icd_decoder.sv
// Instruction class decoder: sorts fetched words into classes and raises the program trap.
`timescale 1ns/1ps

module icd_decoder
  import icd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch side
  input wire logic in_valid,
  input wire icd_fetch_t in_fetch,
  // Exception unit redirect after a trap
  input wire logic exc_redirect,
  // Decode result
  output logic out_valid,
  output icd_dec_t out_dec,
  output logic squashing
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic op31_arith(input logic [8:0] x);
    case (x)
      9'd8, 9'd10, 9'd11, 9'd40, 9'd75, 9'd104, 9'd136, 9'd138, 9'd200, 9'd202,
      9'd232, 9'd234, 9'd235, 9'd266, 9'd459, 9'd491: op31_arith = 1'b1;
      default: op31_arith = 1'b0;
    endcase
  endfunction

  function automatic logic op31_load(input logic [9:0] x);
    case (x)
      10'd20, 10'd23, 10'd55, 10'd87, 10'd119, 10'd279, 10'd310, 10'd311, 10'd343, 10'd375,
      10'd533, 10'd534, 10'd535, 10'd567, 10'd597, 10'd599, 10'd631, 10'd790: op31_load = 1'b1;
      default: op31_load = 1'b0;
    endcase
  endfunction

  function automatic logic op31_store(input logic [9:0] x);
    case (x)
      10'd150, 10'd151, 10'd183, 10'd215, 10'd247, 10'd407, 10'd438, 10'd439, 10'd661, 10'd662,
      10'd663, 10'd695, 10'd725, 10'd727, 10'd759, 10'd918, 10'd983: op31_store = 1'b1;
      default: op31_store = 1'b0;
    endcase
  endfunction

  function automatic logic op31_other(input logic [9:0] x);
    case (x)
      10'd0, 10'd4, 10'd19, 10'd24, 10'd26, 10'd28, 10'd32, 10'd54, 10'd60, 10'd83, 10'd86,
      10'd124, 10'd144, 10'd146, 10'd210, 10'd242, 10'd246, 10'd278, 10'd284, 10'd306, 10'd316,
      10'd339, 10'd371, 10'd412, 10'd444, 10'd467, 10'd470, 10'd476, 10'd512, 10'd536, 10'd566,
      10'd595, 10'd598, 10'd659, 10'd792, 10'd824, 10'd854, 10'd922, 10'd954, 10'd982,
      10'd1014: op31_other = 1'b1;
      default: op31_other = 1'b0;
    endcase
  endfunction

  function automatic logic op19_ok(input logic [9:0] x);
    case (x)
      10'd0, 10'd16, 10'd33, 10'd50, 10'd129, 10'd150, 10'd193, 10'd225, 10'd257, 10'd289,
      10'd417, 10'd449, 10'd528: op19_ok = 1'b1;
      default: op19_ok = 1'b0;
    endcase
  endfunction

  function automatic logic fp_arith_ok(input logic [4:0] x, input logic dbl);
    case (x)
      5'd18, 5'd20, 5'd21, 5'd22, 5'd25, 5'd28, 5'd29, 5'd30, 5'd31: fp_arith_ok = 1'b1;
      5'd24: fp_arith_ok = !dbl;
      5'd23, 5'd26: fp_arith_ok = dbl;
      default: fp_arith_ok = 1'b0;
    endcase
  endfunction

  function automatic logic op63_x_ok(input logic [9:0] x);
    case (x)
      10'd0, 10'd12, 10'd14, 10'd15, 10'd32, 10'd38, 10'd40, 10'd64, 10'd70, 10'd72, 10'd134,
      10'd136, 10'd264, 10'd583, 10'd711: op63_x_ok = 1'b1;
      default: op63_x_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Combinational classification
  // ----------------------------------------------------------------
  logic [5:0] op;
  logic [9:0] xo10;
  logic [4:0] xo5;
  icd_dec_t dec;
  logic unimpl;

  assign op = in_fetch.word[ICD_OP_MSB:ICD_OP_LSB];
  assign xo10 = in_fetch.word[ICD_XO10_MSB:ICD_XO10_LSB];
  assign xo5 = in_fetch.word[ICD_XO5_MSB:ICD_XO5_LSB];

  always_comb begin
    dec = '0;
    unimpl = 1'b0;
    dec.cls = ICD_DEFINED;
    dec.pc = {in_fetch.pc[31:2], 2'b00};
    dec.reg_d = in_fetch.word[ICD_RD_LSB +: ICD_REG_W];
    dec.reg_a = in_fetch.word[ICD_RA_LSB +: ICD_REG_W];
    dec.reg_b = in_fetch.word[ICD_RB_LSB +: ICD_REG_W];
    unique case (op)
      6'd0: begin
        dec.cls = (in_fetch.word == '0) ? ICD_ILLEGAL : ICD_RESERVED;
      end
      6'd1, 6'd4, 6'd5, 6'd6, 6'd9, 6'd22, 6'd56, 6'd60, 6'd61: dec.cls = ICD_ILLEGAL;
      6'd2, 6'd30, 6'd58, 6'd62: dec.cls = ICD_ILLEGAL;
      6'd17: dec.cls = in_fetch.word[1] ? ICD_DEFINED : ICD_ILLEGAL;
      6'd19: begin
        dec.cls = op19_ok(xo10) ? ICD_DEFINED : ICD_ILLEGAL;
        dec.ctx_change = (xo10 == 10'd50);
      end
      6'd31: begin
        if (op31_load(xo10)) begin
          dec.mem_rd = 1'b1;
        end else if (op31_store(xo10)) begin
          dec.mem_wr = 1'b1;
        end else if (xo10 == 10'd370) begin
          unimpl = 1'b1;
        end else if (!op31_other(xo10) && !op31_arith(xo10[8:0])) begin
          dec.cls = ICD_ILLEGAL;
        end
        dec.float_regs = (op31_load(xo10) || op31_store(xo10)) && xo10[9] && xo10[6:5] != 2'b10
          && xo10 != 10'd533 && xo10 != 10'd534 && xo10 != 10'd597 && xo10 != 10'd661
          && xo10 != 10'd662 && xo10 != 10'd725 && xo10 != 10'd790 && xo10 != 10'd918;
        dec.ctx_change = (xo10 == 10'd146);
      end
      6'd59, 6'd63: begin
        dec.float_regs = 1'b1;
        if (fp_arith_ok(xo5, op[2])) begin
          unimpl = (xo5 == 5'd22);
        end else if (!(op[2] && op63_x_ok(xo10))) begin
          dec.cls = ICD_ILLEGAL;
        end
      end
      default: begin
        dec.mem_rd = (op >= 6'd32) && (op <= 6'd55) && (!op[2] || op == 6'd46);
        dec.mem_wr = (op >= 6'd32) && (op <= 6'd55) && op[2] && op != 6'd46;
        dec.float_regs = (op >= 6'd48) && (op <= 6'd55);
      end
    endcase
    dec.trap = (dec.cls != ICD_DEFINED) || unimpl;
    dec.vector = dec.trap ? ICD_PROG_VECTOR : ICD_NO_VECTOR;
    if (dec.trap) begin
      dec.mem_rd = 1'b0;
      dec.mem_wr = 1'b0;
      dec.ctx_change = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output stage and precise trap squash
  // ----------------------------------------------------------------
  logic next_out_valid;
  icd_dec_t next_out_dec;
  logic next_squashing;

  always_comb begin
    next_out_valid = in_valid && !squashing;
    next_out_dec = next_out_valid ? dec : '0;
    next_squashing = squashing;
    if (exc_redirect) begin
      next_squashing = 1'b0;
    end
    if (next_out_valid && dec.trap) begin
      next_squashing = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_dec <= '0;
      squashing <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_dec <= next_out_dec;
      squashing <= next_squashing;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_zero_word;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && in_fetch.word == '0 |=> out_dec.cls == ICD_ILLEGAL && out_dec.trap;
  endproperty
  a_zero_word: assert property (p_zero_word) else $error("zero word not illegal");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && op == 6'd0 && in_fetch.word != '0 |=> out_dec.cls == ICD_RESERVED && out_dec.trap;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved class wrong");

  property p_illegal_ops;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && (op == 6'd1 || op == 6'd9 || op == 6'd22 || op == 6'd61) |=> out_dec.trap;
  endproperty
  a_illegal_ops: assert property (p_illegal_ops) else $error("illegal opcode not trapped");

  property p_wide_ops;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && (op == 6'd2 || op == 6'd30 || op == 6'd58 || op == 6'd62)
      |=> out_dec.cls == ICD_ILLEGAL;
  endproperty
  a_wide_ops: assert property (p_wide_ops) else $error("64-bit opcode not illegal");

  property p_vector;
    @(posedge clk) disable iff (!rst_n)
    out_valid |-> (out_dec.trap ? out_dec.vector == 20'h00700 : out_dec.vector == 20'h00000);
  endproperty
  a_vector: assert property (p_vector) else $error("trap vector wrong");

  property p_sqrt;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && op == 6'd63 && xo5 == 5'd22 |=> out_dec.trap && out_dec.cls == ICD_DEFINED;
  endproperty
  a_sqrt: assert property (p_sqrt) else $error("square root not trapped");

  property p_defined_runs;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && op == 6'd14 |=> out_valid && !out_dec.trap;
  endproperty
  a_defined_runs: assert property (p_defined_runs) else $error("defined add-immediate trapped");

  property p_no_priv;
    @(posedge clk) disable iff (!rst_n)
    out_dec.trap |-> !out_dec.mem_rd && !out_dec.mem_wr && !out_dec.ctx_change;
  endproperty
  a_no_priv: assert property (p_no_priv) else $error("trapping word granted access");

  property p_aligned;
    @(posedge clk) disable iff (!rst_n)
    out_valid |-> out_dec.pc == ($past(in_fetch.pc) & ~{30'h0, ICD_ALIGN_MASK});
  endproperty
  a_aligned: assert property (p_aligned) else $error("pc not word aligned");

  property p_arith_no_mem;
    @(posedge clk) disable iff (!rst_n)
    in_valid && !squashing && op == 6'd31 && xo10 == 10'd266 |=> !out_dec.mem_rd && !out_dec.mem_wr;
  endproperty
  a_arith_no_mem: assert property (p_arith_no_mem) else $error("arithmetic touched memory");

  property p_squash;
    @(posedge clk) disable iff (!rst_n)
    out_valid && out_dec.trap |-> squashing ##1 !out_valid;
  endproperty
  a_squash: assert property (p_squash) else $error("younger instruction passed a trap");

  c_trap: cover property (@(posedge clk) disable iff (!rst_n) out_valid && out_dec.trap);
  c_load: cover property (@(posedge clk) disable iff (!rst_n) out_valid && out_dec.mem_rd);
  c_redirect: cover property (@(posedge clk) disable iff (!rst_n) squashing ##1 !squashing);

endmodule

// File: src/icd_pkg.sv
// Shared types and constants for the instruction class decoder.
package icd_pkg;

  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int ICD_WORD_W = 32;
  localparam int ICD_REG_W = 5;
  localparam int ICD_OP_MSB = 31;
  localparam int ICD_OP_LSB = 26;
  localparam int ICD_RD_LSB = 21;
  localparam int ICD_RA_LSB = 16;
  localparam int ICD_RB_LSB = 11;
  localparam int ICD_XO10_MSB = 10;
  localparam int ICD_XO10_LSB = 1;
  localparam int ICD_XO5_MSB = 5;
  localparam int ICD_XO5_LSB = 1;
  localparam logic [1:0] ICD_ALIGN_MASK = 2'h3;

  // ----------------------------------------------------------------
  // Exception vector and reset values
  // ----------------------------------------------------------------
  localparam logic [19:0] ICD_PROG_VECTOR = 20'h00700;
  localparam logic [19:0] ICD_NO_VECTOR = 20'h00000;
  localparam logic [31:0] ICD_PC_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ICD_DEFINED,
    ICD_ILLEGAL,
    ICD_RESERVED
  } icd_class_t;

  typedef struct packed {
    logic [31:0] word;
    logic [31:0] pc;
  } icd_fetch_t;

  typedef struct packed {
    icd_class_t cls;
    logic trap;
    logic [19:0] vector;
    logic [31:0] pc;
    logic [4:0] reg_d;
    logic [4:0] reg_a;
    logic [4:0] reg_b;
    logic float_regs;
    logic mem_rd;
    logic mem_wr;
    logic ctx_change;
  } icd_dec_t;

endpackage

// File: testbench/icd_exc_model.sv
// Exception unit model: answers a trap with a redirect pulse after a chosen delay.
`timescale 1ns/1ps
module icd_exc_model
  import icd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decode result seen
  input wire logic out_valid,
  input wire icd_dec_t out_dec,
  // Extra wait before the redirect
  input wire logic [2:0] delay,
  // Redirect pulse
  output logic exc_redirect
);
  logic [3:0] cnt;

  // Counts down after each trap and pulses the redirect for one cycle at the end.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      exc_redirect <= 1'b0;
    end else begin
      exc_redirect <= (cnt == 4'h1);
      if (out_valid && out_dec.trap) begin
        cnt <= {1'b0, delay} + 4'h2;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// File: testbench/instruction_class_decoder_bench.sv
// Self-checking bench for the instruction class decoder.
`timescale 1ns/1ps
module instruction_class_decoder_bench;
  import icd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  icd_fetch_t in_fetch = '0;
  logic exc_redirect;
  logic out_valid;
  logic squashing;
  icd_dec_t out_dec;
  logic [2:0] delay = 3'h2;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  logic pdrop = 1'b1;
  logic sq = 1'b0;
  icd_fetch_t pf;

  always #10 clk = ~clk;

  icd_decoder icd_decoder_i (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_fetch(in_fetch),
    .exc_redirect(exc_redirect), .out_valid(out_valid), .out_dec(out_dec), .squashing(squashing));
  icd_exc_model icd_exc_model_i (.clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_dec(out_dec),
    .delay(delay), .exc_redirect(exc_redirect));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Works out the expected decode of one fetched word.
  function automatic icd_dec_t expect_of(input icd_fetch_t f);
    icd_dec_t e;
    logic [5:0] o;
    o = f.word[31:26];
    e = '0;
    e.pc = {f.pc[31:2], 2'h0};
    e.reg_d = f.word[25:21];
    e.reg_a = f.word[20:16];
    e.reg_b = f.word[15:11];
    e.cls = ICD_DEFINED;
    if (o inside {1, 4, 5, 6, 9, 22, 56, 60, 61, 2, 30, 58, 62} || f.word == 32'h0 || (o == 17 && !f.word[1])) begin
      e.cls = ICD_ILLEGAL;
    end else if (o == 0) begin
      e.cls = ICD_RESERVED;
    end
    e.trap = (e.cls != ICD_DEFINED) || ((o == 59 || o == 63) && f.word[5:1] == 5'h16) ||
      (o == 31 && f.word[10:1] == 10'h172);
    e.vector = e.trap ? ICD_PROG_VECTOR : ICD_NO_VECTOR;
    if (!e.trap) begin
      e.mem_rd = (o inside {[32:55]}) && (o == 46 || (o != 47 && !f.word[28]));
      e.mem_wr = (o inside {[32:55]}) && !e.mem_rd;
      e.float_regs = o inside {[48:55], 59, 63};
    end
    return e;
  endfunction

  // Checks what the last edge produced, then presents the next word.
  task automatic send(input logic v, input logic [31:0] wd);
    icd_dec_t e;
    @(negedge clk);
    e = expect_of(pf);
    if (pdrop) begin
      chk(out_valid, 1'b0);
    end else begin
      chk(out_valid, 1'b1);
      chk(out_dec.cls, e.cls);
      chk(out_dec.trap, e.trap);
      chk(out_dec.vector, e.vector);
      chk(out_dec.pc, e.pc);
      chk({out_dec.mem_rd, out_dec.mem_wr, out_dec.ctx_change}, {e.mem_rd, e.mem_wr, 1'b0});
      if (e.trap) chk(squashing, 1'b1);
      else chk({out_dec.reg_d, out_dec.reg_a, out_dec.reg_b, out_dec.float_regs},
        {e.reg_d, e.reg_a, e.reg_b, e.float_regs});
    end
    in_valid = v;
    in_fetch = '{word: wd, pc: $urandom()};
    pf = in_fetch;
    pdrop = !v || sq;
    if (v && !sq && expect_of(in_fetch).trap) sq = 1'b1;
  endtask

  // Presents one word; after a trap offers a word that must drop and waits for the redirect.
  task automatic issue(input logic [31:0] wd);
    send(1'b1, wd);
    if (sq) begin
      delay = 3'($urandom_range(0, 7));
      send(1'b1, $urandom());
      for (int i = 0; i < 40 && squashing !== 1'b0; i++) send(1'b0, 32'h0);
      chk(squashing, 1'b0);
      sq = 1'b0;
    end
  endtask

  function automatic logic [31:0] word_for(input int op);
    logic [31:0] r;
    r = $urandom();
    return {6'(op), r[25:0]};
  endfunction

  task automatic conclude();
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    int op;
    void'($urandom(42));
    repeat (6) @(negedge clk);
    chk({out_valid, squashing}, 2'h0);
    rst_n = 1'b1;
    for (int k = 0; k < 64; k++) if (!(k inside {17, 19, 31, 57, 59, 63})) issue(word_for(k));
    issue(32'h00000000);
    issue(32'h00000001);
    issue(word_for(17) & 32'hFFFFFFFD);
    issue({6'h3B, 20'($urandom()), 5'h16, 1'b0});
    issue({6'h3F, 15'h0, 5'h3, 5'h16, 1'b1});
    issue({6'h1F, 15'h0, 10'h172, 1'b0});
    for (int n = 0; n < 300; n++) begin
      do op = $urandom_range(0, 63); while (op inside {17, 19, 31, 57, 59, 63});
      issue(word_for(op));
    end
    send(1'b0, 32'h0);
    conclude();
  end
endmodule
